// ---- core/bridge_consts.svh ----
`ifndef BRIDGE_CONSTS_SVH
`define BRIDGE_CONSTS_SVH
// ****************************************
// Register byte offsets
// ****************************************
`define OFS_MODE_STATUS  8'h00
`define OFS_GPIO_OE      8'h04
`define OFS_GPIO_OUT     8'h08
`define OFS_GPIO_IN      8'h0c
`define OFS_GP_OUTPUT    8'h10
`define OFS_CLOCK_ENABLE 8'h14
// ****************************************
// Field positions of the mode status word
// ****************************************
`define POS_TEST_MODE    0
`define POS_SMBUS_SEL    1
`define POS_NONTRANSP    2
`define POS_EXTERNAL_ARB 3
`define POS_REVERSE      4
`define POS_HOTPLUG_EN   5
`define POS_TEST_FUNC    8
// ****************************************
// Reset values and pin masks
// ****************************************
`define GPIO_OE_RST      4'h0
`define GPIO_OUT_RST     4'h0
`define GP_OUTPUT_RST    4'h0
`define CLOCK_ENABLE_RST 9'h1ff
`define EXT_PIN_MASK     8'h3d
`endif

// ---- core/bridge_pkg.sv ----
package bridge_pkg;
  typedef struct packed {
    logic test_mode;
    logic smbus_sel;
    logic nontransparent;
    logic external_arb;
    logic reverse;
    logic hotplug_en;
  } mode_type;

  typedef struct packed {
    logic scl_drive;
    logic sda_out;
    logic sda_oe;
  } sideband_type;

  // Code is {sideband strap, transparency strap, clock mask strap}
  typedef enum logic [2:0] {
    TF_RSVD0        = 3'b000,
    TF_PLL          = 3'b001,
    TF_SHORT_INIT   = 3'b010,
    TF_SHORT_INIT_HP = 3'b011,
    TF_RSVD4        = 3'b100,
    TF_LOOPBACK     = 3'b101,
    TF_RSVD6        = 3'b110,
    TF_BRIDGE       = 3'b111
  } test_func_type;

  typedef enum logic {
    BUS_IDLE = 1'b0,
    BUS_READ = 1'b1
  } bus_state_type;
endpackage : bridge_pkg

// ---- core/strap_capture.sv ----
`timescale 1ns/10ps
module strap_capture
  import bridge_pkg::*;
(
  input  wire logic    clk_i,
  input  wire logic    reset_n_i,
  input  wire logic    test_select_i,
  input  wire logic    sideband_select_i,
  input  wire logic    transparency_select_i,
  input  wire logic    clock_mask_i,
  input  wire logic    direction_select_i,
  input  wire logic    arbiter_select_n_i,
  input  wire logic    link_reset_n_i,
  input  wire logic    bus_reset_n_i,
  output mode_type     mode_o,
  output test_func_type test_func_o
);
  logic          init_done_reg;
  logic          link_prev_reg;
  logic          bus_prev_reg;
  mode_type      mode_reg, mode_next;
  test_func_type test_func_reg, test_func_next;

  // Normal selects are taken once, first cycle after reset release;
  // the board keeps them steady afterwards
  wire take_normal = ~init_done_reg;
  wire link_rise   = ~link_prev_reg & link_reset_n_i;
  wire bus_rise    = ~bus_prev_reg & bus_reset_n_i;
  wire rev_now     = take_normal ? direction_select_i : mode_reg.reverse;
  wire test_now    = take_normal ? test_select_i : mode_reg.test_mode;
  wire take_test   = rev_now ? bus_rise : link_rise;
  wire normal_now  = ~test_select_i;

  always_comb begin
    mode_next      = mode_reg;
    test_func_next = test_func_reg;
    if (take_normal) begin
      mode_next.test_mode      = test_select_i;
      mode_next.smbus_sel      = normal_now & sideband_select_i;
      mode_next.nontransparent = normal_now & transparency_select_i;
      mode_next.external_arb   = normal_now & arbiter_select_n_i;
      mode_next.reverse        = direction_select_i;
    end
    if (take_test) begin
      mode_next.hotplug_en = clock_mask_i;
      if (test_now) begin
        test_func_next = test_func_type'({sideband_select_i,
                           transparency_select_i, clock_mask_i});
      end
    end
  end

  always_ff @(posedge clk_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      init_done_reg <= 1'b0;
      link_prev_reg <= 1'b0;
      bus_prev_reg  <= 1'b0;
      mode_reg      <= '0;
      test_func_reg <= TF_RSVD0;
    end else begin
      init_done_reg <= 1'b1;
      link_prev_reg <= link_reset_n_i;
      bus_prev_reg  <= bus_reset_n_i;
      mode_reg      <= mode_next;
      test_func_reg <= test_func_next;
    end
  end

  assign mode_o      = mode_reg;
  assign test_func_o = test_func_reg;

  property p_test_capture;
    @(posedge clk_i) disable iff (!reset_n_i)
    (init_done_reg && !mode_reg.reverse && link_rise && mode_reg.test_mode)
    |=> test_func_reg == $past({sideband_select_i,
                                transparency_select_i, clock_mask_i});
  endproperty
  a_test_capture: assert property (p_test_capture)
    else $error("test straps not captured at link reset release");

  property p_mode_hold;
    @(posedge clk_i) disable iff (!reset_n_i)
    init_done_reg |=> $stable({mode_reg.smbus_sel, mode_reg.reverse,
                       mode_reg.nontransparent, mode_reg.external_arb});
  endproperty
  a_mode_hold: assert property (p_mode_hold)
    else $error("decoded mode changed after capture");

  property p_test_gate;
    @(posedge clk_i) disable iff (!reset_n_i)
    mode_reg.test_mode |-> !(mode_reg.smbus_sel ||
                             mode_reg.nontransparent || mode_reg.external_arb);
  endproperty
  a_test_gate: assert property (p_test_gate)
    else $error("normal decodes active in test mode");
endmodule : strap_capture

// ---- core/serial_pin_ctrl.sv ----
`timescale 1ns/10ps
module serial_pin_ctrl
  import bridge_pkg::*;
(
  input  wire logic   clk_i,
  input  wire logic   reset_n_i,
  input  wire logic   smbus_sel_i,
  input  sideband_type sb_i,
  output logic        scl_o,
  output logic        scl_oe_o,
  output logic        sda_o,
  output logic        sda_oe_o
);
  // SMBus: clock is the master's, data only ever pulled low
  wire scl_oe_next = ~smbus_sel_i;
  wire sda_o_next  = smbus_sel_i ? 1'b0 : sb_i.sda_out;
  wire sda_oe_next = smbus_sel_i ? (sb_i.sda_oe & ~sb_i.sda_out)
                                 : sb_i.sda_oe;

  always_ff @(posedge clk_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      scl_o    <= 1'b0;
      scl_oe_o <= 1'b0;
      sda_o    <= 1'b0;
      sda_oe_o <= 1'b0;
    end else begin
      scl_o    <= sb_i.scl_drive & scl_oe_next;
      scl_oe_o <= scl_oe_next;
      sda_o    <= sda_o_next;
      sda_oe_o <= sda_oe_next;
    end
  end

  property p_smbus_scl_in;
    @(posedge clk_i) disable iff (!reset_n_i)
    smbus_sel_i |=> !scl_oe_o && !scl_o;
  endproperty
  a_smbus_scl_in: assert property (p_smbus_scl_in)
    else $error("scl driven in smbus mode");

  property p_eeprom_sda;
    @(posedge clk_i) disable iff (!reset_n_i)
    reset_n_i && !smbus_sel_i |=> sda_oe_o == $past(sb_i.sda_oe) &&
                     sda_o == $past(sb_i.sda_out);
  endproperty
  a_eeprom_sda: assert property (p_eeprom_sda)
    else $error("sda not bidirectional in eeprom mode");
endmodule : serial_pin_ctrl

// ---- core/bridge_mode_strap_decode.sv ----
`timescale 1ns/10ps
`include "bridge_consts.svh"
// Contract
// - Test strap low means normal operation, high selects test decodes.
// - Normal mode: sideband select 0 is EEPROM, 1 is SMBus.
// - Transparency select 0 is transparent, 1 is non-transparent bridge.
// - Direction select 0 is forward, 1 is reverse bridging.
// - Arbiter select low uses internal arbiter; high needs board arbiter.
// - External arbiter: request input 0 becomes our bus grant input.
// - External arbiter: grant output 0 becomes our bus request output.
// - External arbiter: requests 5:2 are inputs, grants 5:2 outputs.
// - Clock mask input enables or disables the secondary clock outputs.
// - Clock mask strapped high enables hot-plug.
// - Four general pins are input-only or bidirectional by software enable.
// - EEPROM sideband: serial clock pin is driven as an output.
// - SMBus sideband: serial clock pin is an input.
// - EEPROM sideband: serial data pin is bidirectional.
// - SMBus sideband: serial data pin is open-drain, pulls low only.
// - Test straps captured at link reset release forward, bus reset reverse.
module bridge_mode_strap_decode
  import bridge_pkg::*;
#(
  parameter int unsigned CLOCK_OUT_COUNT = 9,
  parameter int unsigned CLOCK_OUT_DIV   = 1
)(
  input  wire logic        CLK_I,
  input  wire logic        RESET_N_I,
  input  wire logic        TEST_SELECT_STRAP_I,
  input  wire logic        SIDEBAND_INTERFACE_SELECT_I,
  input  wire logic        TRANSPARENCY_SELECT_I,
  input  wire logic        CLOCK_OUTPUT_MASK_I,
  input  wire logic        BRIDGE_DIRECTION_SELECT_I,
  input  wire logic        ARBITER_SELECT_N_I,
  input  wire logic        LINK_RESET_N_I,
  input  wire logic        BUS_RESET_N_I,
  input  wire logic        HSEL_I,
  input  wire logic [31:0] HADDR_I,
  input  wire logic [1:0]  HTRANS_I,
  input  wire logic        HWRITE_I,
  input  wire logic [2:0]  HSIZE_I,
  input  wire logic [31:0] HWDATA_I,
  input  wire logic        HREADY_I,
  output logic      [31:0] HRDATA_O,
  output logic             HREADYOUT_O,
  output logic             HRESP_O,
  input  wire logic [7:0]  REQ_N_I,
  output logic      [7:0]  GNT_N_O,
  input  wire logic [7:0]  ARB_GNT_N_I,
  output logic      [7:0]  ARB_REQ_N_O,
  input  wire logic        BRIDGE_REQ_N_I,
  output logic             BRIDGE_GNT_N_O,
  input  wire logic [3:0]  GPIO_I,
  output logic      [3:0]  GPIO_O,
  output logic      [3:0]  GPIO_OE_O,
  output logic [CLOCK_OUT_COUNT-1:0] SECONDARY_CLOCK_OUT_O,
  input  sideband_type     SIDEBAND_I,
  output logic             SB_SCL_IN_O,
  output logic             SB_SDA_IN_O,
  input  wire logic        SCL_I,
  output logic             SCL_O,
  output logic             SCL_OE_O,
  input  wire logic        SDA_I,
  output logic             SDA_O,
  output logic             SDA_OE_O,
  output mode_type         MODE_O,
  output test_func_type    TEST_FUNC_O
);
  // ****************************************
  // Strap capture and pin direction control
  // ****************************************
  mode_type mode;

  strap_capture u_strap (
    .clk_i                 (CLK_I),
    .reset_n_i             (RESET_N_I),
    .test_select_i         (TEST_SELECT_STRAP_I),
    .sideband_select_i     (SIDEBAND_INTERFACE_SELECT_I),
    .transparency_select_i (TRANSPARENCY_SELECT_I),
    .clock_mask_i          (CLOCK_OUTPUT_MASK_I),
    .direction_select_i    (BRIDGE_DIRECTION_SELECT_I),
    .arbiter_select_n_i    (ARBITER_SELECT_N_I),
    .link_reset_n_i        (LINK_RESET_N_I),
    .bus_reset_n_i         (BUS_RESET_N_I),
    .mode_o                (mode),
    .test_func_o           (TEST_FUNC_O)
  );

  assign MODE_O = mode;

  serial_pin_ctrl u_serial (
    .clk_i       (CLK_I),
    .reset_n_i   (RESET_N_I),
    .smbus_sel_i (mode.smbus_sel),
    .sb_i        (SIDEBAND_I),
    .scl_o       (SCL_O),
    .scl_oe_o    (SCL_OE_O),
    .sda_o       (SDA_O),
    .sda_oe_o    (SDA_OE_O)
  );

  // ****************************************
  // Register bus slave
  // ****************************************
  function automatic logic reg_hit(input logic [7:0] a,
                                   input logic [7:0] ofs);
    return a == ofs;
  endfunction

  bus_state_type state_reg, state_next;
  logic [7:0]  addr_reg;
  logic        wr_pend_reg;
  logic [3:0]  gpio_oe_reg;
  logic [3:0]  gpio_out_reg;
  logic [3:0]  gp_output_reg;
  logic [CLOCK_OUT_COUNT-1:0] clk_en_reg;

  // Reads take one wait state so a write just before is visible
  wire addr_take = HSEL_I & HTRANS_I[1] & HREADY_I;
  wire rd_take   = addr_take & ~HWRITE_I;
  wire wr_go     = wr_pend_reg;

  always_comb begin
    case (state_reg)
      BUS_IDLE: state_next = rd_take ? BUS_READ : BUS_IDLE;
      BUS_READ: state_next = BUS_IDLE;
      default:  state_next = BUS_IDLE;
    endcase
  end

  wire hit_mode = reg_hit(addr_reg, `OFS_MODE_STATUS);
  wire hit_oe   = reg_hit(addr_reg, `OFS_GPIO_OE);
  wire hit_out  = reg_hit(addr_reg, `OFS_GPIO_OUT);
  wire hit_in   = reg_hit(addr_reg, `OFS_GPIO_IN);
  wire hit_gp_out = reg_hit(addr_reg, `OFS_GP_OUTPUT);
  wire hit_clk  = reg_hit(addr_reg, `OFS_CLOCK_ENABLE);

  // General inputs only exist while the request pins are freed
  wire [3:0] gp_input = mode.external_arb ? REQ_N_I[5:2] : 4'h0;

  wire [31:0] mode_word = 32'({TEST_FUNC_O, 2'b00,
                               mode.hotplug_en, mode.reverse,
                               mode.external_arb, mode.nontransparent,
                               mode.smbus_sel, mode.test_mode});
  wire [31:0] rd_data =
    hit_mode ? mode_word :
    hit_oe   ? {28'h0, gpio_oe_reg} :
    hit_out  ? {28'h0, gpio_out_reg} :
    hit_in   ? {24'h0, gp_input, GPIO_I} :
    hit_gp_out ? {28'h0, gp_output_reg} :
    hit_clk  ? 32'(clk_en_reg) :
    32'h0;

  always_ff @(posedge CLK_I or negedge RESET_N_I) begin
    if (!RESET_N_I) begin
      state_reg   <= BUS_IDLE;
      addr_reg    <= 8'h00;
      wr_pend_reg <= 1'b0;
      HREADYOUT_O <= 1'b1;
      HRESP_O     <= 1'b0;
      HRDATA_O    <= 32'h0;
    end else begin
      state_reg   <= state_next;
      wr_pend_reg <= addr_take & HWRITE_I;
      HREADYOUT_O <= state_next != BUS_READ;
      HRESP_O     <= 1'b0;
      if (addr_take) begin
        addr_reg <= HADDR_I[7:0];
      end
      if (state_reg == BUS_READ) begin
        HRDATA_O <= rd_data;
      end
    end
  end

  // Unmapped writes fall through every hit and are dropped
  always_ff @(posedge CLK_I or negedge RESET_N_I) begin
    if (!RESET_N_I) begin
      gpio_oe_reg  <= `GPIO_OE_RST;
      gpio_out_reg <= `GPIO_OUT_RST;
      gp_output_reg <= `GP_OUTPUT_RST;
      clk_en_reg   <= CLOCK_OUT_COUNT'(`CLOCK_ENABLE_RST);
    end else if (wr_go) begin
      if (hit_oe)  gpio_oe_reg  <= HWDATA_I[3:0];
      if (hit_out) gpio_out_reg <= HWDATA_I[3:0];
      if (hit_gp_out) gp_output_reg <= HWDATA_I[3:0];
      if (hit_clk) clk_en_reg   <= HWDATA_I[CLOCK_OUT_COUNT-1:0];
    end
  end

  // ****************************************
  // General purpose pins and sideband inputs
  // ****************************************
  always_ff @(posedge CLK_I or negedge RESET_N_I) begin
    if (!RESET_N_I) begin
      GPIO_O      <= 4'h0;
      GPIO_OE_O   <= 4'h0;
      SB_SCL_IN_O <= 1'b1;
      SB_SDA_IN_O <= 1'b1;
    end else begin
      GPIO_O      <= gpio_out_reg;
      GPIO_OE_O   <= gpio_oe_reg;
      SB_SCL_IN_O <= SCL_I;
      SB_SDA_IN_O <= SDA_I;
    end
  end

  // ****************************************
  // Arbiter pin routing
  // ****************************************
  // Unused grant pins stay deasserted in external mode
  wire [7:0] gnt_n_next = mode.external_arb ?
    {2'b11, gp_output_reg, 1'b1, BRIDGE_REQ_N_I} :
    ARB_GNT_N_I;
  // Pins given to the external arbiter never reach the internal one
  wire [7:0] arb_req_n_next = mode.external_arb ?
    (REQ_N_I | `EXT_PIN_MASK) : REQ_N_I;
  wire bridge_gnt_n_next = mode.external_arb ? REQ_N_I[0] : 1'b1;

  always_ff @(posedge CLK_I or negedge RESET_N_I) begin
    if (!RESET_N_I) begin
      GNT_N_O        <= 8'hff;
      ARB_REQ_N_O    <= 8'hff;
      BRIDGE_GNT_N_O <= 1'b1;
    end else begin
      GNT_N_O        <= gnt_n_next;
      ARB_REQ_N_O    <= arb_req_n_next;
      BRIDGE_GNT_N_O <= bridge_gnt_n_next;
    end
  end

  // ****************************************
  // Secondary clock outputs
  // ****************************************
  // Fastest output is half the core clock; a gated flop output
  // cannot glitch, at the cost of that rate limit
  localparam logic [7:0] DIV_LAST = 8'(CLOCK_OUT_DIV - 1);
  logic [7:0] div_cnt_reg;
  logic       phase_reg;
  wire        div_tick = div_cnt_reg == DIV_LAST;

  always_ff @(posedge CLK_I or negedge RESET_N_I) begin
    if (!RESET_N_I) begin
      div_cnt_reg <= 8'h00;
      phase_reg   <= 1'b0;
    end else begin
      div_cnt_reg <= div_tick ? 8'h00 : div_cnt_reg + 8'h01;
      if (div_tick) begin
        phase_reg <= ~phase_reg;
      end
    end
  end

  genvar gi;
  generate
    for (gi = 0; gi < CLOCK_OUT_COUNT; gi++) begin : g_clock_out
      wire clk_next = phase_reg & clk_en_reg[gi] &
                      ~CLOCK_OUTPUT_MASK_I;
      always_ff @(posedge CLK_I or negedge RESET_N_I) begin
        if (!RESET_N_I) begin
          SECONDARY_CLOCK_OUT_O[gi] <= 1'b0;
        end else begin
          SECONDARY_CLOCK_OUT_O[gi] <= clk_next;
        end
      end
    end
  endgenerate

  // ****************************************
  // Checks
  // ****************************************
  property p_ext_grant;
    @(posedge CLK_I) disable iff (!RESET_N_I)
    mode.external_arb |=> BRIDGE_GNT_N_O == $past(REQ_N_I[0]);
  endproperty
  a_ext_grant: assert property (p_ext_grant)
    else $error("external grant not routed from request 0");

  property p_ext_req;
    @(posedge CLK_I) disable iff (!RESET_N_I)
    mode.external_arb |=> GNT_N_O[0] == $past(BRIDGE_REQ_N_I);
  endproperty
  a_ext_req: assert property (p_ext_req)
    else $error("bridge request not on grant 0");

  property p_gp_output_map;
    @(posedge CLK_I) disable iff (!RESET_N_I)
    mode.external_arb |=> GNT_N_O[5:2] == $past(gp_output_reg) &&
                          ARB_REQ_N_O[5:2] == 4'hf;
  endproperty
  a_gp_output_map: assert property (p_gp_output_map)
    else $error("general outputs not on grants 5:2");

  property p_int_arb;
    @(posedge CLK_I) disable iff (!RESET_N_I)
    // Sampled reset keeps the release-edge attempt off reset values
    RESET_N_I && !mode.external_arb |=>
      GNT_N_O == $past(ARB_GNT_N_I) && BRIDGE_GNT_N_O;
  endproperty
  a_int_arb: assert property (p_int_arb)
    else $error("internal grants not passed through");

  property p_clk_masked;
    @(posedge CLK_I) disable iff (!RESET_N_I)
    CLOCK_OUTPUT_MASK_I |=> SECONDARY_CLOCK_OUT_O == '0;
  endproperty
  a_clk_masked: assert property (p_clk_masked)
    else $error("secondary clock runs while masked");

  property p_sda_open_drain;
    @(posedge CLK_I) disable iff (!RESET_N_I)
    mode.smbus_sel |=> !(SDA_OE_O && SDA_O);
  endproperty
  a_sda_open_drain: assert property (p_sda_open_drain)
    else $error("sda driven high in smbus mode");

  property p_eeprom_scl;
    @(posedge CLK_I) disable iff (!RESET_N_I)
    RESET_N_I && !mode.smbus_sel |=>
      SCL_OE_O && SCL_O == $past(SIDEBAND_I.scl_drive);
  endproperty
  a_eeprom_scl: assert property (p_eeprom_scl)
    else $error("scl not driven in eeprom mode");

  property p_gpio_oe_write;
    @(posedge CLK_I) disable iff (!RESET_N_I)
    (wr_go && hit_oe) |=> ##1 GPIO_OE_O == $past(HWDATA_I[3:0], 2);
  endproperty
  a_gpio_oe_write: assert property (p_gpio_oe_write)
    else $error("gpio enable write not applied");

  property p_read_wait;
    @(posedge CLK_I) disable iff (!RESET_N_I)
    rd_take |=> !HREADYOUT_O ##1 HREADYOUT_O && !HRESP_O;
  endproperty
  a_read_wait: assert property (p_read_wait)
    else $error("read answer timing wrong");

  c_ext_mode: cover property (@(posedge CLK_I) mode.external_arb);
  c_smbus: cover property (@(posedge CLK_I) mode.smbus_sel && SDA_OE_O);
  c_read: cover property (@(posedge CLK_I) rd_take ##2 HREADYOUT_O);
  c_hotplug: cover property (@(posedge CLK_I) mode.hotplug_en);
endmodule : bridge_mode_strap_decode

// ---- tb/board_side_model.sv ----
`timescale 1ns/10ps
module board_side_model (
  input  wire logic       clk_i,
  input  wire logic [5:0] strap_i,
  input  wire logic [7:0] req_n_i,
  input  wire logic       bus_req_n_i,
  input  wire logic [1:0] lat_i,
  output logic      [5:0] strap_o,
  output logic      [7:0] req_n_o
);
  logic       grant_reg = 1'b0;
  logic [1:0] wait_reg  = 2'h0;
  // ****
  // Straps
  // ****
  // Resistors: the level only moves when the board is re-strapped
  assign strap_o = strap_i;
  // ****
  // External arbiter
  // ****
  // Grant after lat_i idle cycles, so both prompt and slow answers occur
  always_ff @(posedge clk_i) begin
    if (bus_req_n_i) begin
      grant_reg <= 1'b0;
      wait_reg  <= lat_i;
    end else if (wait_reg != 2'h0) begin
      wait_reg <= wait_reg - 2'h1;
    end else begin
      grant_reg <= 1'b1;
    end
  end
  assign req_n_o = {req_n_i[7:1],
                    req_n_i[0] & ~(strap_i[0] & grant_reg)};
endmodule : board_side_model

// ---- tb/bridge_mode_strap_decode_tb_top.sv ----
`timescale 1ns/10ps
`include "bridge_consts.svh"
module bridge_mode_strap_decode_tb_top
  import bridge_pkg::*;
;
  logic         clk = 1'b0;
  logic         rst_n = 1'b0;
  logic [5:0]   strap = 6'h0;
  logic         lrst_n = 1'b1;
  logic         brst_n = 1'b1;
  logic [31:0]  haddr = 32'h0;
  logic [1:0]   htrans = 2'h0;
  logic         hwrite = 1'b0;
  logic [31:0]  hwdata = 32'h0;
  logic [7:0]   arb_gnt_n = 8'hff;
  logic [7:0]   req_n = 8'hff;
  logic         breq_n = 1'b1;
  logic [3:0]   gp_ext = 4'h0;
  logic [1:0]   lat = 2'h0;
  sideband_type sb = 3'h0;
  logic [31:0]  hrdata;
  logic         hready;
  logic [7:0]   gnt_n, arb_req_n, preq_n;
  logic         bgnt_n, scl_o, scl_oe, sda_o, sda_oe, scl_w, sda_w;
  logic         hresp, sb_scl_in, sb_sda_in;
  logic [3:0]   gpio_o, gpio_oe, gpio_w;
  logic [8:0]   sclk, ck0;
  logic [5:0]   pstrap;
  mode_type     mode;
  test_func_type tf;
  logic [4:0]   c;
  logic         ext;
  logic [4:0]   cmb [4] = '{5'h00, 5'h1f, 5'h15, 5'h0a};
  logic [2:0]   sbv [2] = '{3'h7, 3'h1};
  int           n_mismatch = 0;
  int           n_compared = 0;

  always #12.5 clk = ~clk;
  // Serial wires resolve with pull-ups; general pins take gp_ext where not driven
  assign scl_w  = scl_oe ? scl_o : 1'b1;
  assign sda_w  = sda_oe ? sda_o : 1'b1;
  assign gpio_w = (gpio_oe & gpio_o) | (~gpio_oe & gp_ext);

  board_side_model u_board_side_model (.clk_i(clk), .strap_i(strap),
    .req_n_i(req_n), .bus_req_n_i(gnt_n[0]), .lat_i(lat),
    .strap_o(pstrap), .req_n_o(preq_n));

  bridge_mode_strap_decode u_bridge_mode_strap_decode (
    .CLK_I(clk), .RESET_N_I(rst_n), .TEST_SELECT_STRAP_I(pstrap[5]),
    .SIDEBAND_INTERFACE_SELECT_I(pstrap[4]),
    .TRANSPARENCY_SELECT_I(pstrap[3]), .CLOCK_OUTPUT_MASK_I(pstrap[2]),
    .BRIDGE_DIRECTION_SELECT_I(pstrap[1]), .ARBITER_SELECT_N_I(pstrap[0]),
    .LINK_RESET_N_I(lrst_n), .BUS_RESET_N_I(brst_n), .HSEL_I(1'b1),
    .HADDR_I(haddr), .HTRANS_I(htrans), .HWRITE_I(hwrite),
    .HSIZE_I(3'h2), .HWDATA_I(hwdata), .HREADY_I(hready),
    .HRDATA_O(hrdata), .HREADYOUT_O(hready), .HRESP_O(hresp),
    .REQ_N_I(preq_n), .GNT_N_O(gnt_n), .ARB_GNT_N_I(arb_gnt_n),
    .ARB_REQ_N_O(arb_req_n), .BRIDGE_REQ_N_I(breq_n),
    .BRIDGE_GNT_N_O(bgnt_n), .GPIO_I(gpio_w), .GPIO_O(gpio_o),
    .GPIO_OE_O(gpio_oe), .SECONDARY_CLOCK_OUT_O(sclk), .SIDEBAND_I(sb),
    .SB_SCL_IN_O(sb_scl_in), .SB_SDA_IN_O(sb_sda_in), .SCL_I(scl_w),
    .SCL_O(scl_o),
    .SCL_OE_O(scl_oe), .SDA_I(sda_w), .SDA_O(sda_o), .SDA_OE_O(sda_oe),
    .MODE_O(mode), .TEST_FUNC_O(tf));

  // ****
  // Tasks
  // ****
  task automatic finish_test;
    if (n_mismatch == 0 && n_compared > 0) begin
      $display("Result: passed");
    end else begin
      $display("Result: failed");
    end
    $finish;
  endtask : finish_test

  task automatic chk(input string nm, input logic [31:0] e,
                     input logic [31:0] g);
    n_compared++;
    if (g !== e) begin
      n_mismatch++;
      $display("[ERR] %s expected %h seen %h", nm, e, g);
    end
  endtask : chk

  task automatic wait_rdy;
    int n;
    n = 0;
    do begin
      @(posedge clk);
      n++;
    end while (hready !== 1'b1 && n < 50);
    if (hready !== 1'b1) begin
      n_mismatch++;
      finish_test();
    end
  endtask : wait_rdy

  task automatic xfer(input logic wr, input logic [7:0] a,
                      input logic [31:0] wd, output logic [31:0] rd);
    htrans <= 2'h2;
    haddr  <= {24'h0, a};
    hwrite <= wr;
    wait_rdy();
    htrans <= 2'h0;
    hwdata <= wd;
    wait_rdy();
    rd = hrdata;
  endtask : xfer

  task automatic wreg(input logic [7:0] a, input logic [31:0] d);
    logic [31:0] x;
    xfer(1'b1, a, d, x);
  endtask : wreg

  task automatic rchk(input string nm, input logic [7:0] a,
                      input logic [31:0] e);
    logic [31:0] x;
    xfer(1'b0, a, 32'h0, x);
    chk(nm, e, x);
    chk("hresp", 32'h0, {31'h0, hresp});
  endtask : rchk

  task automatic do_reset(input logic [5:0] s, input logic lr);
    strap  <= s;
    lrst_n <= lr;
    brst_n <= lr;
    rst_n  <= 1'b0;
    repeat (10) @(posedge clk);
    rst_n <= 1'b1;
    repeat (3) @(posedge clk);
  endtask : do_reset

  // Forward captures on link release only, reverse on bus release only
  task automatic tcap(input logic [5:0] s, input logic [2:0] tfe,
                      input logic [5:0] me);
    do_reset(s, 1'b0);
    chk("tf_idle", 32'h0, {29'h0, tf});
    lrst_n <= 1'b1;
    repeat (3) @(posedge clk);
    chk("tf_link", {29'h0, s[1] ? 3'h0 : tfe}, {29'h0, tf});
    brst_n <= 1'b1;
    repeat (3) @(posedge clk);
    chk("tf_bus", {29'h0, tfe}, {29'h0, tf});
    chk("tmode", {26'h0, me}, {26'h0, mode});
  endtask : tcap

  // ****
  // Sequence
  // ****
  initial begin
    for (int i = 0; i < 4; i++) begin
      c = cmb[i];
      ext = c[0];
      do_reset({1'b0, c}, 1'b1);
      chk("mode", {26'h0, 1'b0, c[4], c[3], c[0], c[1], c[2]},
          {26'h0, mode});
      wreg(`OFS_MODE_STATUS, 32'hffffffff);
      rchk("status", `OFS_MODE_STATUS,
           {26'h0, c[2], c[1], c[0], c[3], c[4], 1'b0});
      rchk("clk_en", `OFS_CLOCK_ENABLE, 32'h1ff);
      wreg(8'h20, 32'hffffffff);
      rchk("unmapped", 8'h20, 32'h0);
      req_n     <= 8'h97;
      arb_gnt_n <= 8'h5a;
      breq_n    <= 1'b0;
      lat       <= 2'(i);
      gp_ext    <= 4'h3;
      wreg(`OFS_GP_OUTPUT, 32'ha);
      wreg(`OFS_GPIO_OE, 32'hc);
      wreg(`OFS_GPIO_OUT, 32'h5);
      repeat (8) @(posedge clk);
      chk("pins", {ext ? 8'hea : 8'h5a, 8'h97 | (ext ? `EXT_PIN_MASK : 8'h0),
          4'hc, 4'h5, 7'h0, ~ext}, {gnt_n, arb_req_n, gpio_oe, gpio_o,
          7'h0, bgnt_n});
      rchk("gpio_in", `OFS_GPIO_IN,
           {24'h0, ext ? 4'h5 : 4'h0, 4'h7});
      breq_n <= 1'b1;
      wreg(`OFS_CLOCK_ENABLE, 32'h0aa);
      for (int k = 0; k < 2; k++) begin
        sb <= sbv[k];
        repeat (3) @(posedge clk);
        chk("serial", c[4] ? {31'h0, sbv[k][0] & ~sbv[k][1]}
            : {28'h0, sbv[k][2], 1'b1, sbv[k][1], sbv[k][0]},
            {28'h0, scl_o, scl_oe, sda_o, sda_oe});
        // Pins read back through the pull-ups when nobody drives them
        chk("sb_in", {30'h0, c[4] | sbv[k][2], ~sbv[k][0] | sbv[k][1]},
            {30'h0, sb_scl_in, sb_sda_in});
      end
      ck0 = sclk;
      @(posedge clk);
      chk("secondary_clock_out", c[2] ? 32'h0 : {23'h0, ~ck0 & 9'h0aa},
          {23'h0, sclk});
      // Straps move behind the decode's back; the decode must not follow
      strap <= {1'b0, ~c[4], ~c[3], c[2], ~c[1], ~c[0]};
      repeat (3) @(posedge clk);
      chk("mode_hold", {26'h0, 1'b0, c[4], c[3], c[0], c[1], c[2]},
          {26'h0, mode});
    end
    tcap(6'b101101, 3'b011, 6'b100001);
    tcap(6'b110010, 3'b100, 6'b100010);
    finish_test();
  end
endmodule : bridge_mode_strap_decode_tb_top
